// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import tmr8_pkg::*;
;
	logic clk, rst_n, wr_en, rd_en, ext, pin, oe_n, ovf, go, busy, p;
	logic [7:0] addr, wdata, rdata, d;
	int errors = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	tmr8_wave i_tmr8_wave(.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_en),
		.I_RD(rd_en), .I_EXT_CLK(ext), .O_RDATA(rdata), .O_COMPARE_B_OUTPUT_PIN(pin),
		.O_COMPARE_B_PIN_OE_N(oe_n), .O_OVERFLOW_FLAG(ovf));
	tmr8_ext_src i_tmr8_ext_src(.i_clk(clk), .i_go(go), .i_edges(8'h0A), .o_ext(ext), .o_busy(busy));
	task print_verdict;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// The idle edge after each write keeps two writes in a row from driving the strobe twice in one time step.
	task bus_wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	// Realigns to a rising edge so the next call may follow back to back.
	task bus_rd(input logic [7:0] a);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	// Looks on the falling edge, clear of the flops' update, then realigns to a rising edge for the next call.
	task wait_for(input logic use_pin, input logic v, input int lim);
		int n;
		n = 0;
		@(negedge clk);
		while (((use_pin ? pin : ovf) !== v) && n < lim) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		if (n >= lim) begin
			errors++;
			$display("FAIL %0t wait expired", $time);
			print_verdict();
		end
	endtask
	task do_reset;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask
	// Compare values are loaded in an immediate mode first so the buffered modes start known.
	task setup(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ma, input logic [7:0] mb,
		input logic [7:0] cnt);
		do_reset();
		bus_wr(ADDR_CTRL_A, ca & 8'hFC);
		bus_wr(ADDR_CMP_A, ma);
		bus_wr(ADDR_CMP_B, mb);
		bus_wr(ADDR_COUNT, cnt);
		bus_wr(ADDR_CTRL_A, ca);
		bus_wr(ADDR_CTRL_B, cb);
	endtask
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		go = 1'b0;
		do_reset();
		cmp({7'h00, oe_n}, 8'h01);
		bus_rd(ADDR_CTRL_A);
		cmp(d, RESET_BYTE);
		bus_wr(ADDR_CTRL_A, 8'hFF);
		bus_rd(ADDR_CTRL_A);
		cmp(d, 8'hF3);
		cmp({7'h00, oe_n}, 8'h00);
		bus_wr(ADDR_CTRL_B, 8'hFF);
		bus_rd(ADDR_CTRL_B);
		cmp(d, 8'h0F);
		bus_wr(ADDR_CMP_B, 8'h5A);
		bus_rd(ADDR_CMP_B);
		cmp(d, 8'h5A);
		bus_rd(8'h06);
		cmp(d, 8'h00);
		bus_wr(ADDR_CTRL_A, 8'h00);
		bus_rd(ADDR_CTRL_A);
		cmp({7'h00, oe_n}, 8'h01);
		for (int i = 0; i < 2; i++) begin
			p = i[0];
			setup(i[0] ? 8'h31 : 8'h21, 8'h01, 8'h00, 8'h10, 8'h00);
			wait_for(1'b1, p, 60);
			wait_for(1'b1, !p, 600);
			bus_rd(ADDR_COUNT);
			cmp({7'h00, d >= 8'h08 && d <= 8'h10}, 8'h01);
			bus_rd(ADDR_STATUS);
			cmp(d & 8'h02, 8'h02);
			bus_wr(ADDR_STATUS, 8'h01);
			wait_for(1'b0, 1'b1, 40);
			bus_rd(ADDR_COUNT);
			cmp({7'h00, d <= 8'h05}, 8'h01);
			wait_for(1'b1, p, 40);
			bus_rd(ADDR_COUNT);
			cmp({7'h00, d >= 8'h10 && d <= 8'h16}, 8'h01);
		end
		setup(8'h21, 8'h01, 8'h00, 8'hFF, 8'h00);
		wait_for(1'b1, 1'b1, 600);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d >= 8'hF8}, 8'h01);
		setup(8'h00, 8'h01, 8'h00, 8'h00, 8'hF0);
		wait_for(1'b0, 1'b1, 40);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d <= 8'h05}, 8'h01);
		bus_wr(ADDR_STATUS, 8'h01);
		bus_rd(ADDR_STATUS);
		cmp(d & 8'h01, 8'h00);
		setup(8'h02, 8'h01, 8'h20, 8'h00, 8'h00);
		repeat (300) @(posedge clk);
		bus_rd(ADDR_STATUS);
		cmp(d & 8'h01, 8'h00);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d <= 8'h20}, 8'h01);
		setup(8'h01, 8'h09, 8'h20, 8'h00, 8'h00);
		repeat (40) @(posedge clk);
		bus_rd(ADDR_STATUS);
		cmp(d & 8'h02, 8'h02);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d >= 8'h10 && d <= 8'h20}, 8'h01);
		setup(8'h03, 8'h09, 8'h20, 8'h00, 8'h00);
		wait_for(1'b0, 1'b1, 60);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d <= 8'h05}, 8'h01);
		setup(8'h03, 8'h01, 8'h00, 8'h00, 8'hF0);
		wait_for(1'b0, 1'b1, 40);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d <= 8'h05}, 8'h01);
		setup(8'h00, 8'h02, 8'h00, 8'h00, 8'h00);
		repeat (80) @(posedge clk);
		bus_rd(ADDR_COUNT);
		cmp({7'h00, d >= 8'h09 && d <= 8'h0B}, 8'h01);
		setup(8'h00, 8'h07, 8'h00, 8'h00, 8'h00);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		for (int n = 0; n < 200 && busy === 1'b1; n++)
			@(posedge clk);
		if (busy !== 1'b0) begin
			errors++;
			$display("FAIL %0t burst never ended", $time);
			print_verdict();
		end
		repeat (6) @(posedge clk);
		bus_rd(ADDR_COUNT);
		cmp(d, 8'h0A);
		print_verdict();
	end
endmodule
`default_nettype wire

// >>> test/tmr8_ext_src.sv
`timescale 1ns/1ns
`default_nettype none
// External count source; the line rests low between bursts.
module tmr8_ext_src #(
	parameter int HALF = 3
) (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_edges,
	output logic o_ext,
	output logic o_busy
);
	initial begin
		o_ext = 1'b0;
		o_busy = 1'b0;
	end
	// Half periods of three clocks keep the rate well below the sampler's limit with margin.
	always begin : burst
		int n;
		@(posedge i_clk);
		if (i_go) begin
			o_busy <= 1'b1;
			n = i_edges;
			repeat (n) begin
				repeat (HALF) @(posedge i_clk);
				o_ext <= 1'b1;
				repeat (HALF) @(posedge i_clk);
				o_ext <= 1'b0;
			end
			o_busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> test/tmr8_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tmr8_sva
	import tmr8_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_EXT_CLK,
	input wire logic [7:0] O_RDATA,
	input wire logic O_COMPARE_B_OUTPUT_PIN,
	input wire logic O_COMPARE_B_PIN_OE_N,
	input wire logic O_OVERFLOW_FLAG
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);
	wire logic wr_a = I_WR && I_ADDR == ADDR_CTRL_A;
	wire logic rd_a = I_RD && I_ADDR == ADDR_CTRL_A;
	chk_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00) else $error("read data outside read");
	chk_ctrla_rsvd: assert property (rd_a |=> O_RDATA[3:2] == 2'b00) else $error("reserved bits set");
	chk_ctrla_back: assert property (wr_a ##1 !I_WR ##1 rd_a
		|=> O_RDATA == ($past(I_WDATA, 3) & CTRL_A_RW_MASK)) else $error("control A readback");
	chk_ctrlb_back: assert property (I_WR && I_ADDR == ADDR_CTRL_B ##1 !I_WR ##1 I_RD && I_ADDR == ADDR_CTRL_B
		|=> O_RDATA == ($past(I_WDATA, 3) & CTRL_B_RW_MASK)) else $error("control B readback");
	chk_cmpb_back: assert property (I_WR && I_ADDR == ADDR_CMP_B ##1 !I_WR ##1 I_RD && I_ADDR == ADDR_CMP_B
		|=> O_RDATA == $past(I_WDATA, 3)) else $error("compare B buffer readback");
	// Checked two cycles on so the rule holds whether the enable is one or two flops deep.
	chk_pin_enable: assert property (wr_a ##1 !wr_a ##1 1'b1 |-> O_COMPARE_B_PIN_OE_N == !$past(I_WDATA[CTRL_A_COMB_HI], 2))
		else $error("pin enable wrong");
	chk_ovf_clear: assert property ($fell(O_OVERFLOW_FLAG) |-> $past(I_WR && I_ADDR == ADDR_STATUS && I_WDATA[STATUS_OVF]))
		else $error("flag fell without clear");
	chk_status_ovf: assert property (I_RD && I_ADDR == ADDR_STATUS |=> O_RDATA[STATUS_OVF] == $past(O_OVERFLOW_FLAG))
		else $error("status flag bit");
	chk_unmapped_rd: assert property (I_RD && I_ADDR > ADDR_STATUS |=> O_RDATA == 8'h00) else $error("unmapped read");
	cover property ($rose(O_OVERFLOW_FLAG));
	cover property ($rose(O_COMPARE_B_OUTPUT_PIN));
	cover property ($fell(O_COMPARE_B_PIN_OE_N));
endmodule
bind tmr8_wave tmr8_sva i_tmr8_sva(.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
	.I_WR(I_WR), .I_RD(I_RD), .I_EXT_CLK(I_EXT_CLK), .O_RDATA(O_RDATA), .O_COMPARE_B_OUTPUT_PIN(O_COMPARE_B_OUTPUT_PIN),
	.O_COMPARE_B_PIN_OE_N(O_COMPARE_B_PIN_OE_N), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG));
`default_nettype wire

// >>> verilog/tmr8_ext_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser plus edge detector for the external count pin.
module tmr8_ext_sync (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	input wire logic i_rise_sel,
	output logic o_edge
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	wire rise = s2_r & ~s3_r;
	wire fall = ~s2_r & s3_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= i_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign o_edge = i_rise_sel ? rise : fall;
endmodule
`default_nettype wire

// >>> verilog/tmr8_pkg.sv
package tmr8_pkg;
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h01;
	localparam logic [7:0] ADDR_COUNT = 8'h02;
	localparam logic [7:0] ADDR_CMP_A = 8'h03;
	localparam logic [7:0] ADDR_CMP_B = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h05;
	localparam logic [7:0] CTRL_A_RW_MASK = 8'hF3;
	localparam logic [7:0] CTRL_B_RW_MASK = 8'h0F;
	localparam int CTRL_A_COMB_HI = 5;
	localparam int CTRL_A_COMB_LO = 4;
	localparam int CTRL_A_WGM_HI = 1;
	localparam int CTRL_B_WGM2 = 3;
	localparam int STATUS_OVF = 0;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [9:0] PRE_DIV8 = 10'h007;
	localparam logic [9:0] PRE_DIV64 = 10'h03F;
	localparam logic [9:0] PRE_DIV256 = 10'h0FF;
	localparam logic [9:0] PRE_DIV1024 = 10'h3FF;
	typedef enum logic [2:0] {
		WM_NORMAL = 3'h0,
		WM_PC_FIX = 3'h1,
		WM_CTC = 3'h2,
		WM_FAST_FIX = 3'h3,
		WM_RSV4 = 3'h4,
		WM_PC_VAR = 3'h5,
		WM_RSV6 = 3'h6,
		WM_FAST_VAR = 3'h7
	} wave_mode_e;
endpackage

// >>> verilog/tmr8_prescale.sv
`timescale 1ns/1ns
`default_nettype none
// Prescaler and clock select; produces one-cycle count enables.
module tmr8_prescale
	import tmr8_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ext_pin,
	tmr8_tick_if.src tk
);
	logic [9:0] pre_r;
	logic ext_edge;
	tmr8_ext_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_ext_pin),
		.i_rise_sel(tk.clock_select_bits == CS_EXT_RISE),
		.o_edge(ext_edge)
	);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) pre_r <= 10'h000;
		else pre_r <= pre_r + 10'h001;
	end
	function automatic logic due(input logic [9:0] cnt, input logic [9:0] msk);
		due = ((cnt & msk) == msk);
	endfunction
	always_comb begin
		unique case (tk.clock_select_bits)
			3'h0: tk.tick = 1'b0;
			3'h1: tk.tick = 1'b1;
			3'h2: tk.tick = due(pre_r, PRE_DIV8);
			3'h3: tk.tick = due(pre_r, PRE_DIV64);
			3'h4: tk.tick = due(pre_r, PRE_DIV256);
			3'h5: tk.tick = due(pre_r, PRE_DIV1024);
			3'h6, 3'h7: tk.tick = ext_edge;
		endcase
	end
endmodule
`default_nettype wire

// >>> verilog/tmr8_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tmr8_tick_if;
	logic [2:0] clock_select_bits;
	logic tick;
	modport src(input clock_select_bits, output tick);
	modport dst(output clock_select_bits, input tick);
endinterface
`default_nettype wire

// >>> verilog/tmr8_wave.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module tmr8_wave
	import tmr8_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_EXT_CLK,
	output logic [7:0] O_RDATA,
	output logic O_COMPARE_B_OUTPUT_PIN,
	output logic O_COMPARE_B_PIN_OE_N,
	output logic O_OVERFLOW_FLAG
);
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [7:0] count_r;
	logic [7:0] cmp_a_buf_r;
	logic [7:0] cmp_b_buf_r;
	logic [7:0] compare_a_value_r;
	logic [7:0] compare_b_value_r;
	logic down_r;
	logic ovf_r;
	logic pin_r;
	logic oe_n_r;
	logic [7:0] rdata_r;
	logic [7:0] count_nxt;
	logic down_nxt;
	logic pin_nxt;

	tmr8_tick_if tk ();
	tmr8_prescale u_pre (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RESET_N),
		.i_ext_pin(I_EXT_CLK),
		.tk(tk)
	);

	wave_mode_e mode;
	assign mode = wave_mode_e'({ctrl_b_r[CTRL_B_WGM2], ctrl_a_r[CTRL_A_WGM_HI:0]});
	assign tk.clock_select_bits = ctrl_b_r[2:0];
	wire tick = tk.tick;
	wire compare_b_output_mode_hi = ctrl_a_r[CTRL_A_COMB_HI];
	wire compare_b_output_mode_lo = ctrl_a_r[CTRL_A_COMB_LO];
	wire top_is_a = (mode == WM_CTC) || (mode == WM_PC_VAR) || (mode == WM_FAST_VAR);
	wire [7:0] top_val = top_is_a ? compare_a_value_r : CNT_MAX;
	wire phase_correct = (mode == WM_PC_FIX) || (mode == WM_PC_VAR);
	wire immediate = (mode == WM_NORMAL) || (mode == WM_CTC);
	wire at_top = (count_r == top_val);
	wire at_bottom = (count_r == CNT_BOTTOM);
	wire at_max = (count_r == CNT_MAX);
	wire wr_cmp_a = I_WR && (I_ADDR == ADDR_CMP_A);
	wire wr_cmp_b = I_WR && (I_ADDR == ADDR_CMP_B);
	wire wr_status = I_WR && (I_ADDR == ADDR_STATUS);
	// Update point: TOP for phase-correct and fixed fast PWM, BOTTOM for variable fast PWM.
	wire upd_point = (mode == WM_FAST_VAR) ? at_bottom : at_top;
	wire do_update = tick && !immediate && upd_point;
	wire ovf_event = tick && (phase_correct ? at_bottom :
		((mode == WM_FAST_VAR) ? at_top : at_max));
	wire b_at_top = (compare_b_value_r == top_val) && compare_b_output_mode_hi;
	wire b_match = (count_r == compare_b_value_r) && !b_at_top;
	wire out_drive = compare_b_output_mode_hi;

	// Counter sequence: phase-correct bounces, all others wrap at TOP.
	always_comb begin
		count_nxt = count_r;
		down_nxt = down_r;
		if (tick) begin
			if (phase_correct) begin
				if (!down_r && at_top) begin
					down_nxt = 1'b1;
					count_nxt = count_r - 8'h01;
				end else if (down_r && at_bottom) begin
					down_nxt = 1'b0;
					count_nxt = count_r + 8'h01;
				end else if (down_r) begin
					count_nxt = count_r - 8'h01;
				end else begin
					count_nxt = count_r + 8'h01;
				end
			end else begin
				down_nxt = 1'b0;
				count_nxt = at_top ? CNT_BOTTOM : count_r + 8'h01;
			end
		end
		if (I_WR && (I_ADDR == ADDR_COUNT)) begin
			count_nxt = I_WDATA;
		end
	end

	// Compare-B pin action; the up/down sense flips with the low mode bit.
	always_comb begin
		pin_nxt = pin_r;
		if (tick && out_drive && phase_correct) begin
			if (b_match) begin
				pin_nxt = down_r ? !compare_b_output_mode_lo : compare_b_output_mode_lo;
			end else if (b_at_top && at_top) begin
				// Match at TOP is ignored; the action happens at the turnaround.
				pin_nxt = !compare_b_output_mode_lo;
			end
		end else if (tick && out_drive && !phase_correct && b_match) begin
			pin_nxt = compare_b_output_mode_lo ? 1'b1 : 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl_a_r <= RESET_BYTE;
			ctrl_b_r <= RESET_BYTE;
		end else if (I_WR && (I_ADDR == ADDR_CTRL_A)) begin
			ctrl_a_r <= I_WDATA & CTRL_A_RW_MASK;
		end else if (I_WR && (I_ADDR == ADDR_CTRL_B)) begin
			ctrl_b_r <= I_WDATA & CTRL_B_RW_MASK;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			count_r <= RESET_BYTE;
			down_r <= 1'b0;
			pin_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			down_r <= down_nxt;
			pin_r <= pin_nxt;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cmp_a_buf_r <= RESET_BYTE;
			cmp_b_buf_r <= RESET_BYTE;
		end else begin
			if (wr_cmp_a) cmp_a_buf_r <= I_WDATA;
			if (wr_cmp_b) cmp_b_buf_r <= I_WDATA;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			compare_a_value_r <= RESET_BYTE;
			compare_b_value_r <= RESET_BYTE;
		end else if (immediate) begin
			// Buffer is bypassed; also flush a pending buffered value on mode change.
			compare_a_value_r <= wr_cmp_a ? I_WDATA : cmp_a_buf_r;
			compare_b_value_r <= wr_cmp_b ? I_WDATA : cmp_b_buf_r;
		end else if (do_update) begin
			compare_a_value_r <= cmp_a_buf_r;
			compare_b_value_r <= cmp_b_buf_r;
		end
	end

	// Hardware set wins over a software write-one clear in the same cycle.
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) ovf_r <= 1'b0;
		else if (ovf_event) ovf_r <= 1'b1;
		else if (wr_status && I_WDATA[STATUS_OVF]) ovf_r <= 1'b0;
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) oe_n_r <= 1'b1;
		else oe_n_r <= !out_drive;
	end

	logic [7:0] rd_mux;
	always_comb begin
		unique case (I_ADDR)
			ADDR_CTRL_A: rd_mux = ctrl_a_r;
			ADDR_CTRL_B: rd_mux = ctrl_b_r;
			ADDR_COUNT: rd_mux = count_r;
			ADDR_CMP_A: rd_mux = cmp_a_buf_r;
			ADDR_CMP_B: rd_mux = cmp_b_buf_r;
			ADDR_STATUS: rd_mux = {6'h00, down_r, ovf_r};
			default: rd_mux = RESET_BYTE;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) rdata_r <= RESET_BYTE;
		else if (I_RD) rdata_r <= rd_mux;
		else rdata_r <= RESET_BYTE;
	end

	assign O_RDATA = rdata_r;
	assign O_COMPARE_B_OUTPUT_PIN = pin_r;
	assign O_COMPARE_B_PIN_OE_N = oe_n_r;
	assign O_OVERFLOW_FLAG = ovf_r;
endmodule
`default_nettype wire
